/* File: core/mem_cmd_device.sv */
// Memory device end: registers the pins each edge and decodes commands
// Assumes controller drives the dev modport from ref_clk logic
//
// What this block and its controller do
// - Decode command from strobes each rising edge
// - Bank pins select bank or mode register
// - Row open takes bank and row
// - Store start; chop bit picks four or eight
// - Fetch start; chop bit picks four or eight
// - Store auto-close bit closes bank after burst; here the bit is only passed out on cmd_auto_close
// - Fetch auto-close bit closes bank after burst; here the bit is only passed out on cmd_auto_close
// - Fixed burst mode ignores chop bit
// - Started bursts always run to completion
// - Idle command leaves running burst untouched
// - Chip select high acts as idle
// - No refresh while in power-down
// - Termination never alters commands; off in sleep
// - Self-sleep leave on clock gate rise
// - Controller waits 512 cycles before writing
// - Controller holds reset pin high normally
// - Short power-down: termination timing uncertain
// - Short idle gap: termination timing uncertain; term_uncertain here follows power-down entry and leave only
// - Controller sends idle on gate edges, except the refresh pattern on self-sleep entry
// - Entry window starts lead cycles before gate; here it starts at the decoded entry and lasts PD_TRANSITION_LEAD cycles
`timescale 1ns/1ns
module mem_cmd_device
    import cmd_decode_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link
    mem_cmd_if.dev link,
    // Configuration
    input wire logic burst_fixed,
    input wire logic fixed_chop,
    // Decoded command
    output cmd_kind_t cmd_kind,
    output logic cmd_valid,
    output logic [BANK_W-1:0] cmd_bank,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic cmd_chop,
    output logic cmd_auto_close,
    // Status
    output logic burst_busy,
    output logic in_low_power,
    output logic in_self_sleep,
    output logic refresh_pulse,
    output logic termination_value,
    output logic term_uncertain
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] cke_s;
        logic [1:0] cs_s;
        logic [1:0] ras_s;
        logic [1:0] cas_s;
        logic [1:0] we_s;
        logic [1:0] odt_s;
        logic [BANK_W-1:0] bank_s1;
        logic [BANK_W-1:0] bank_s2;
        logic [ADDR_W-1:0] addr_s1;
        logic [ADDR_W-1:0] addr_s2;
        logic cke_prev;
        cmd_kind_t kind;
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic chop;
        logic auto_close;
        logic [2:0] burst_cnt;
        logic low_power;
        logic self_sleep;
        logic refresh;
        logic term;
        logic [3:0] unc_cnt;
        logic busy;
        logic unc;
    } dev_state_t;

    dev_state_t st_reg;
    dev_state_t st_next;
    cmd_kind_t kind_w;
    logic cke_now;

    assign cke_now = st_reg.cke_s[1];

    // ----------------------------------------
    // Pin decode
    // ----------------------------------------
    cmd_pattern_decode u_decode (
        .cke_prev(st_reg.cke_prev),
        .cke_now(cke_now),
        .cs_n(st_reg.cs_s[1]),
        .ras_n(st_reg.ras_s[1]),
        .cas_n(st_reg.cas_s[1]),
        .we_n(st_reg.we_s[1]),
        .auto_close(st_reg.addr_s2[AUTO_CLOSE_POS]),
        .kind(kind_w)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.cke_s = {st_reg.cke_s[0], link.cke};
        st_next.cs_s = {st_reg.cs_s[0], link.cs_n};
        st_next.ras_s = {st_reg.ras_s[0], link.ras_n};
        st_next.cas_s = {st_reg.cas_s[0], link.cas_n};
        st_next.we_s = {st_reg.we_s[0], link.we_n};
        st_next.odt_s = {st_reg.odt_s[0], link.termination_ctl};
        st_next.bank_s1 = link.bank;
        st_next.bank_s2 = st_reg.bank_s1;
        st_next.addr_s1 = link.addr;
        st_next.addr_s2 = st_reg.addr_s1;
        st_next.cke_prev = cke_now;
        st_next.kind = kind_w;
        st_next.valid = 1'b1;
        st_next.bank = st_reg.bank_s2;
        st_next.addr = st_reg.addr_s2;
        st_next.auto_close = st_reg.addr_s2[AUTO_CLOSE_POS];
        st_next.chop = burst_fixed ? fixed_chop : !st_reg.addr_s2[CHOP_POS];
        st_next.refresh = 1'b0;
        // ----------------------------------------
        // Burst counter
        // ----------------------------------------
        if (st_reg.burst_cnt != 3'h0)
            st_next.burst_cnt = st_reg.burst_cnt - 3'h1;
        // ----------------------------------------
        // Command effects
        // ----------------------------------------
        case (kind_w)
            CMD_STORE, CMD_FETCH:
                if (st_reg.burst_cnt == 3'h0)
                    st_next.burst_cnt = st_next.chop ? BURST_FOUR_CK : BURST_EIGHT_CK;
            CMD_REFRESH:
                st_next.refresh = !st_reg.low_power;
            CMD_LOW_POWER_ENTER:
            begin
                st_next.low_power = 1'b1;
                st_next.unc_cnt = PD_TRANSITION_LEAD;
            end
            CMD_LOW_POWER_LEAVE:
            begin
                st_next.low_power = 1'b0;
                st_next.unc_cnt = PD_EXIT_TAIL + PD_TRANSITION_LEAD;
            end
            CMD_SELF_SLEEP_ENTER:
                st_next.self_sleep = 1'b1;
            default:
                st_next.valid = (kind_w != CMD_ILLEGAL);
        endcase
        // ----------------------------------------
        // Self-sleep leave and termination
        // ----------------------------------------
        if (st_reg.self_sleep && cke_now)
        begin
            st_next.self_sleep = 1'b0;
            st_next.kind = CMD_SELF_SLEEP_LEAVE;
        end
        if (st_reg.unc_cnt != 4'h0 && kind_w != CMD_LOW_POWER_ENTER
            && kind_w != CMD_LOW_POWER_LEAVE)
            st_next.unc_cnt = st_reg.unc_cnt - 4'h1;
        st_next.term = st_reg.odt_s[1] && !st_next.self_sleep;
        st_next.busy = (st_next.burst_cnt != 3'h0);
        st_next.unc = (st_next.unc_cnt != 4'h0);
    end

    // ----------------------------------------
    // Register update
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
            st_reg.cke_s <= 2'h3;
            st_reg.cke_prev <= 1'b1;
            st_reg.cs_s <= 2'h3;
            st_reg.ras_s <= 2'h3;
            st_reg.cas_s <= 2'h3;
            st_reg.we_s <= 2'h3;
            st_reg.kind <= CMD_IDLE;
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cmd_kind = st_reg.kind;
    assign cmd_valid = st_reg.valid;
    assign cmd_bank = st_reg.bank;
    assign cmd_addr = st_reg.addr;
    assign cmd_chop = st_reg.chop;
    assign cmd_auto_close = st_reg.auto_close;
    assign burst_busy = st_reg.busy;
    assign in_low_power = st_reg.low_power;
    assign in_self_sleep = st_reg.self_sleep;
    assign refresh_pulse = st_reg.refresh;
    assign termination_value = st_reg.term;
    assign term_uncertain = st_reg.unc;
endmodule

/* File: core/cmd_decode_pkg.sv */
// Shared constants and types for the command decoder and its controller end
// Assumes one clock domain and a single active-low asynchronous reset
package cmd_decode_pkg;

    localparam int BANK_W = 3;
    localparam int ADDR_W = 13;
    localparam int AUTO_CLOSE_POS = 10;
    localparam int CHOP_POS = 12;
    localparam int WRITE_LAT = 5;
    localparam logic [3:0] PD_TRANSITION_LEAD = 4'(WRITE_LAT - 1);
    localparam logic [3:0] PD_EXIT_TAIL = 4'h4;
    localparam int SELF_SLEEP_WAIT_CK = 512;
    localparam logic [9:0] SELF_SLEEP_WAIT = 10'(SELF_SLEEP_WAIT_CK);
    localparam logic [2:0] BURST_EIGHT_CK = 3'h4;
    localparam logic [2:0] BURST_FOUR_CK = 3'h2;

    typedef enum logic [4:0] {
        CMD_IDLE,
        CMD_DESELECT,
        CMD_CONFIG_LOAD,
        CMD_REFRESH,
        CMD_SELF_SLEEP_ENTER,
        CMD_SELF_SLEEP_LEAVE,
        CMD_LOW_POWER_ENTER,
        CMD_LOW_POWER_LEAVE,
        CMD_ROW_OPEN,
        CMD_CLOSE_ONE,
        CMD_CLOSE_ALL,
        CMD_STORE,
        CMD_FETCH,
        CMD_CAL_LONG,
        CMD_CAL_SHORT,
        CMD_ILLEGAL
    } cmd_kind_t;

endpackage

/* File: core/mem_cmd_if.sv */
// Command and address pins between controller and memory device
// Assumes both ends run on the same ref_clk
`timescale 1ns/1ns
interface mem_cmd_if;
    import cmd_decode_pkg::*;
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic termination_ctl;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;

    modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_ctl, bank, addr);
    modport dev (input reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_ctl, bank, addr);
endinterface

/* File: core/cmd_pattern_decode.sv */
// Pure pin-pattern to command classifier
// Assumes pins are already synchronised to ref_clk
`timescale 1ns/1ns
module cmd_pattern_decode
    import cmd_decode_pkg::*;
(
    // Command pins
    input wire logic cke_prev,
    input wire logic cke_now,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic auto_close,
    // Result
    output cmd_kind_t kind
);
    always_comb
    begin
        kind = CMD_ILLEGAL;
        if (cke_prev && !cke_now)
        begin
            if (cs_n || (ras_n && cas_n && we_n))
                kind = CMD_LOW_POWER_ENTER;
            else if (!ras_n && !cas_n && we_n)
                kind = CMD_SELF_SLEEP_ENTER;
        end
        else if (!cke_prev && cke_now)
        begin
            if (cs_n || (ras_n && cas_n && we_n))
                kind = CMD_LOW_POWER_LEAVE;
        end
        else if (!cke_prev)
            kind = CMD_IDLE;
        else if (cs_n)
            kind = CMD_DESELECT;
        else
        begin
            case ({ras_n, cas_n, we_n})
                3'h0: kind = CMD_CONFIG_LOAD;
                3'h1: kind = CMD_REFRESH;
                3'h2: kind = auto_close ? CMD_CLOSE_ALL : CMD_CLOSE_ONE;
                3'h3: kind = CMD_ROW_OPEN;
                3'h4: kind = CMD_STORE;
                3'h5: kind = CMD_FETCH;
                3'h6: kind = auto_close ? CMD_CAL_LONG : CMD_CAL_SHORT;
                default: kind = CMD_IDLE;
            endcase
        end
    end
endmodule

/* File: core/mem_cmd_ctrl.sv */
// Controller end: turns user requests into pin patterns
// Assumes one request accepted when req_ready is high
`timescale 1ns/1ns
module mem_cmd_ctrl
    import cmd_decode_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link
    mem_cmd_if.ctrl link,
    // User request
    input wire logic req_valid,
    input cmd_kind_t req_kind,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_term,
    output logic req_ready
);
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic term;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic sleeping;
        logic [9:0] wait_cnt;
        logic ready;
    } ctrl_state_t;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h8;
        st_next.term = req_term;
        if (st_reg.wait_cnt != 10'h0)
            st_next.wait_cnt = st_reg.wait_cnt - 10'h1;
        if (req_valid && st_reg.ready)
        begin
            st_next.bank = req_bank;
            st_next.addr = req_addr;
            case (req_kind)
                CMD_CONFIG_LOAD: {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h0;
                CMD_REFRESH: {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h1;
                CMD_SELF_SLEEP_ENTER:
                begin
                    {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h1;
                    st_next.cke = 1'b0;
                    st_next.sleeping = 1'b1;
                end
                CMD_SELF_SLEEP_LEAVE, CMD_LOW_POWER_LEAVE:
                begin
                    st_next.cke = 1'b1;
                    if (st_reg.sleeping)
                        st_next.wait_cnt = SELF_SLEEP_WAIT;
                    st_next.sleeping = 1'b0;
                end
                CMD_LOW_POWER_ENTER: st_next.cke = 1'b0;
                CMD_ROW_OPEN: {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h3;
                CMD_CLOSE_ONE, CMD_CLOSE_ALL:
                    {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h2;
                CMD_STORE:
                    if (st_reg.wait_cnt == 10'h0)
                        {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h4;
                CMD_FETCH: {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h5;
                CMD_CAL_LONG, CMD_CAL_SHORT:
                    {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h6;
                CMD_IDLE: {st_next.cs_n, st_next.ras_n, st_next.cas_n, st_next.we_n} = 4'h7;
                default: st_next.cs_n = 1'b1;
            endcase
        end
        st_next.ready = !(req_valid && st_reg.ready && req_kind == CMD_STORE
                          && st_reg.wait_cnt != 10'h0);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
            st_reg.cke <= 1'b1;
            st_reg.cs_n <= 1'b1;
            st_reg.ras_n <= 1'b1;
            st_reg.cas_n <= 1'b1;
            st_reg.we_n <= 1'b1;
            st_reg.ready <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign link.reset_n = 1'b1;
    assign link.cke = st_reg.cke;
    assign link.cs_n = st_reg.cs_n;
    assign link.ras_n = st_reg.ras_n;
    assign link.cas_n = st_reg.cas_n;
    assign link.we_n = st_reg.we_n;
    assign link.termination_ctl = st_reg.term;
    assign link.bank = st_reg.bank;
    assign link.addr = st_reg.addr;
    assign req_ready = st_reg.ready;
endmodule

/* File: dv/sdram_command_decode_props.sv */
// Concurrent checks on the command pins and the decoded results
// Assumes the bench wires the link interface and the device outputs here
`timescale 1ns/1ns
module sdram_command_decode_props
    import cmd_decode_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link pins
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    // Device results
    input cmd_kind_t cmd_kind,
    input wire logic cmd_valid,
    input wire logic burst_busy,
    input wire logic in_low_power,
    input wire logic in_self_sleep,
    input wire logic refresh_pulse,
    input wire logic termination_value
);
    // ----------------------------------------
    // Pin patterns
    // ----------------------------------------
    logic sel_lo;
    logic sel_hi;
    assign sel_lo = !cs_n && !ras_n;
    assign sel_hi = !cs_n && ras_n;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reset_pin_high: assert property (reset_n)
        else $error("reset pin low in operation");
    a_deselect_is_idle: assert property (cs_n && cke && $past(cke) |-> ##3
        (!cmd_valid || cmd_kind == CMD_IDLE || cmd_kind == CMD_DESELECT))
        else $error("deselect decoded as a command");
    a_row_open_seen: assert property (sel_lo && cas_n && we_n && cke && $past(cke)
        |-> ##[1:4] cmd_valid && cmd_kind == CMD_ROW_OPEN)
        else $error("row open not decoded");
    a_store_seen: assert property (sel_hi && !cas_n && !we_n && cke
        |-> ##[1:4] cmd_valid && cmd_kind == CMD_STORE)
        else $error("store not decoded");
    a_fetch_seen: assert property (sel_hi && !cas_n && we_n && cke
        |-> ##[1:4] cmd_valid && cmd_kind == CMD_FETCH)
        else $error("fetch not decoded");
    a_close_all_bit: assert property (sel_lo && cas_n && !we_n && addr[AUTO_CLOSE_POS]
        |-> ##[1:4] cmd_kind == CMD_CLOSE_ALL)
        else $error("close all not decoded");
    a_cal_short_bit: assert property (sel_hi && cas_n && !we_n && !addr[AUTO_CLOSE_POS]
        |-> ##[1:4] cmd_kind == CMD_CAL_SHORT)
        else $error("short calibration not decoded");
    a_sleep_term_off: assert property (in_self_sleep |-> !termination_value)
        else $error("termination on in self sleep");
    a_no_refresh_pd: assert property (in_low_power |-> !refresh_pulse)
        else $error("refresh while powered down");
    a_gate_edge_idle: assert property ($changed(cke) |-> cs_n || (ras_n && cas_n && we_n)
        || (!cke && !ras_n && !cas_n && we_n))
        else $error("command on clock gate edge");
    a_burst_runs_on: assert property ($rose(burst_busy) |-> burst_busy[*2])
        else $error("burst cut short");
    c_store: cover property (cmd_valid && cmd_kind == CMD_STORE);
    c_close_all: cover property (cmd_valid && cmd_kind == CMD_CLOSE_ALL);
    c_busy: cover property ($rose(burst_busy));
    c_self_sleep: cover property ($rose(in_self_sleep));
endmodule

/* File: dv/tb_sdram_command_decode.sv */
// Bench joining controller and device ends, with a queue model of results
// Assumes the design's package and link interface are compiled first
`timescale 1ns/1ns
module tb_sdram_command_decode;
    import cmd_decode_pkg::*;
    typedef struct {cmd_kind_t k; logic [2:0] b; logic [12:0] a; logic ch;} exp_t;
    logic ref_clk = 0, arst_n = 0, req_valid = 0, req_term = 0;
    logic burst_fixed = 0, fixed_chop = 0, req_ready;
    cmd_kind_t req_kind = CMD_IDLE, cmd_kind;
    logic [BANK_W-1:0] req_bank = '0, cmd_bank;
    logic [ADDR_W-1:0] req_addr = '0, cmd_addr;
    logic cmd_valid, cmd_chop, cmd_auto_close, burst_busy, in_low_power, in_self_sleep;
    logic refresh_pulse, termination_value, term_uncertain;
    int fails = 0, checks = 0, seed = 32'ha16c;
    exp_t q[$];
    exp_t e;
    cmd_kind_t kinds[9] = '{CMD_ROW_OPEN, CMD_STORE, CMD_FETCH, CMD_CLOSE_ONE, CMD_CLOSE_ALL,
        CMD_CAL_LONG, CMD_CAL_SHORT, CMD_CONFIG_LOAD, CMD_REFRESH};
    mem_cmd_if link_if();
    mem_cmd_ctrl mem_cmd_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(link_if.ctrl),
        .req_valid(req_valid), .req_kind(req_kind), .req_bank(req_bank),
        .req_addr(req_addr), .req_term(req_term), .req_ready(req_ready));
    mem_cmd_device mem_cmd_device_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .link(link_if.dev), .burst_fixed(burst_fixed), .fixed_chop(fixed_chop),
        .cmd_kind(cmd_kind), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
        .cmd_chop(cmd_chop), .cmd_auto_close(cmd_auto_close), .burst_busy(burst_busy),
        .in_low_power(in_low_power), .in_self_sleep(in_self_sleep),
        .refresh_pulse(refresh_pulse), .termination_value(termination_value),
        .term_uncertain(term_uncertain));
    sdram_command_decode_props props_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .reset_n(link_if.reset_n), .cke(link_if.cke), .cs_n(link_if.cs_n),
        .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
        .addr(link_if.addr), .cmd_kind(cmd_kind), .cmd_valid(cmd_valid),
        .burst_busy(burst_busy), .in_low_power(in_low_power), .in_self_sleep(in_self_sleep),
        .refresh_pulse(refresh_pulse), .termination_value(termination_value));
    always #50 ref_clk = !ref_clk;
    // ----------------------------------------
    // Compare and close
    // ----------------------------------------
    task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Request driver
    // ----------------------------------------
    task automatic send(cmd_kind_t k, logic [12:0] a);
        bit got;
        @(negedge ref_clk);
        req_valid = 1;
        req_kind = k;
        req_bank = 3'($random(seed));
        req_addr = a;
        got = 0;
        for (int n = 0; n < 100 && !got; n++)
        begin
            @(posedge ref_clk);
            got = (req_ready === 1'b1);
        end
        if (!got)
        begin
            fails++;
            stop_test();
        end
        e.k = (k == CMD_CLOSE_ONE && a[10]) ? CMD_CLOSE_ALL : k;
        e.b = req_bank;
        e.a = a;
        e.ch = burst_fixed ? fixed_chop : !a[CHOP_POS];
        q.push_back(e);
    endtask
    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (arst_n && cmd_valid === 1'b1 && cmd_kind !== CMD_IDLE && cmd_kind !== CMD_DESELECT)
        begin
            e = q.size() ? q.pop_front() : '{CMD_ILLEGAL, 0, 0, 0};
            cmp("kind", 16'(e.k), 16'(cmd_kind));
            if (e.k inside {CMD_ROW_OPEN, CMD_STORE, CMD_FETCH, CMD_CONFIG_LOAD})
            begin
                cmp("bank", 16'(e.b), 16'(cmd_bank));
                cmp("addr", 16'(e.a), 16'(cmd_addr));
            end
            if (e.k inside {CMD_STORE, CMD_FETCH})
            begin
                cmp("chop", 16'(e.ch), 16'(cmd_chop));
                cmp("auto_close", 16'(e.a[10]), 16'(cmd_auto_close));
            end
            if (e.k == CMD_REFRESH)
                cmp("refresh_pulse", 16'h1, 16'(refresh_pulse));
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [12:0] a;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1;
        for (int i = 0; i < 72; i++)
        begin
            if (i == 36)
            begin
                @(negedge ref_clk);
                req_valid = 0;
                repeat (12) @(negedge ref_clk);
                burst_fixed = 1;
                fixed_chop = 1;
            end
            a = 13'($random(seed));
            if (kinds[i % 9] == CMD_CAL_LONG || kinds[i % 9] == CMD_CLOSE_ALL)
                a[10] = 1;
            if (kinds[i % 9] == CMD_CAL_SHORT)
                a[10] = 0;
            send(kinds[i % 9], a);
            if (i % 5 == 0)
            begin
                @(negedge ref_clk);
                req_valid = 0;
                req_term = 1'($random(seed));
                repeat (3) @(posedge ref_clk);
            end
        end
        @(negedge ref_clk);
        req_valid = 0;
        repeat (20) @(posedge ref_clk);
        // Power-down with a refresh attempt inside it
        send(CMD_LOW_POWER_ENTER, '0);
        @(negedge ref_clk);
        req_valid = 0;
        repeat (3) @(negedge ref_clk);
        cmp("in_low_power", 16'h1, 16'(in_low_power));
        cmp("term_uncertain", 16'h1, 16'(term_uncertain));
        send(CMD_REFRESH, '0);
        void'(q.pop_back());
        @(negedge ref_clk);
        req_valid = 0;
        repeat (3) @(negedge ref_clk);
        cmp("refresh_pulse", 16'h0, 16'(refresh_pulse));
        repeat (8) @(negedge ref_clk);
        cmp("term_uncertain", 16'h0, 16'(term_uncertain));
        send(CMD_LOW_POWER_LEAVE, '0);
        @(negedge ref_clk);
        req_valid = 0;
        req_term = 1;
        repeat (3) @(negedge ref_clk);
        cmp("in_low_power", 16'h0, 16'(in_low_power));
        cmp("term_uncertain", 16'h1, 16'(term_uncertain));
        // Self-sleep with termination held on, then a store too early
        repeat (12) @(negedge ref_clk);
        cmp("termination_value", 16'h1, 16'(termination_value));
        send(CMD_SELF_SLEEP_ENTER, '0);
        @(negedge ref_clk);
        req_valid = 0;
        repeat (3) @(negedge ref_clk);
        cmp("in_self_sleep", 16'h1, 16'(in_self_sleep));
        cmp("termination_value", 16'h0, 16'(termination_value));
        send(CMD_SELF_SLEEP_LEAVE, '0);
        @(negedge ref_clk);
        req_kind = CMD_STORE;
        @(negedge ref_clk);
        req_valid = 0;
        burst_fixed = 0;
        cmp("req_ready", 16'h0, 16'(req_ready));
        repeat (2) @(negedge ref_clk);
        cmp("in_self_sleep", 16'h0, 16'(in_self_sleep));
        cmp("termination_value", 16'h1, 16'(termination_value));
        repeat (520) @(negedge ref_clk);
        // Eight-beat store runs its full count
        send(CMD_STORE, 13'h1400);
        @(negedge ref_clk);
        req_valid = 0;
        repeat (3) @(negedge ref_clk);
        cmp("burst_busy", 16'h1, 16'(burst_busy));
        repeat (3) @(negedge ref_clk);
        cmp("burst_busy", 16'h1, 16'(burst_busy));
        @(negedge ref_clk);
        cmp("burst_busy", 16'h0, 16'(burst_busy));
        cmp("left", 16'h0000, 16'(q.size()));
        stop_test();
    end
endmodule
